//--- adc_control_and_irq.sv
// Control, result and interrupt logic of a four-channel 8-bit successive-approximation converter
`include "adc_ctrl_consts.svh"

module adc_control_and_irq #(
	parameter int SAMPLE_DELAY = `SAMPLE_DELAY_CYCLES,
	parameter int SAMPLE_HOLD  = `SAMPLE_HOLD_CYCLES
) (
	// Clock and reset
	input  wire logic                  core_clk,
	input  wire logic                  rst,
	// Register port
	input  wire adc_ctrl_pkg::addr_t   reg_addr,
	input  wire adc_ctrl_pkg::nibble_t reg_wdata,
	input  wire logic                  reg_write,
	input  wire logic                  reg_read,
	output adc_ctrl_pkg::nibble_t      reg_rdata,
	// Conversion clock ticks, one-cycle enables
	input  wire logic                  osc_half_tick,
	input  wire logic                  prescaler_clock,
	// Analog front end
	output logic [3:0]                 analog_pin_enable,
	output logic [1:0]                 sample_channel,
	output logic                       sample_hold,
	output adc_ctrl_pkg::result_t      sar_trial,
	input  wire logic                  comparator_high,
	// Status and interrupt
	output logic                       conv_busy,
	input  wire logic                  cpu_irq_enable,
	output logic                       adc_irq
);
	import adc_ctrl_pkg::*;

	initial begin
		if (SAMPLE_DELAY < 1 || SAMPLE_DELAY > 255 || SAMPLE_HOLD < 1 || SAMPLE_HOLD > 255) begin
			$error("sample counts must lie in 1..255");
		end
	end

	localparam logic [7:0] DELAY_LAST = 8'(SAMPLE_DELAY - 1);
	localparam logic [7:0] HOLD_LAST  = 8'(SAMPLE_HOLD - 1);
	// A literal cannot be bit-selected, so the control reset value gets a name first
	localparam nibble_t    CONTROL_INIT = `CONTROL_RESET;

	// ------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------
	logic        channel_select_lo_reg;
	logic        channel_select_hi_reg;
	logic        conv_clock_source_sel_reg;
	logic [3:0]  pin_enable_reg;
	logic        conv_done_irq_enable_reg;
	logic        conv_done_flag_reg;
	result_t     result_reg;
	result_t     sar_reg;
	result_t     sar_next;
	logic [2:0]  bit_idx_reg;
	logic [7:0]  cnt_reg;
	conv_state_e state_reg;
	conv_state_e state_next;

	// ------------------------------------------------------------
	// Address decode and strobes
	// ------------------------------------------------------------
	wire hit_control = (reg_addr == `ADC_CONTROL_OFS);
	wire hit_pins    = (reg_addr == `ADC_PIN_ENABLE_OFS);
	wire hit_res_lo  = (reg_addr == `ADC_RESULT_LOW_OFS);
	wire hit_res_hi  = (reg_addr == `ADC_RESULT_HIGH_OFS);
	wire hit_mask    = (reg_addr == `ADC_IRQ_MASK_OFS);
	wire hit_flag    = (reg_addr == `ADC_IRQ_FLAG_OFS);
	wire wr_control  = reg_write && hit_control;
	wire wr_pins     = reg_write && hit_pins;
	wire wr_mask     = reg_write && hit_mask;
	wire flag_clear  = reg_write && hit_flag && reg_wdata[`IRQ_BIT];
	wire start_req   = wr_control && reg_wdata[`START_BIT];
	wire idle        = (state_reg == CONV_IDLE);
	wire start_take  = start_req && idle;

	// Selected conversion clock tick; conversion pace follows it
	wire conv_tick   = conv_clock_source_sel_reg ? osc_half_tick : prescaler_clock;

	// ------------------------------------------------------------
	// Conversion sequencer
	// ------------------------------------------------------------
	// Every phase but the store advances only on a selected conversion tick, so
	// total time is SAMPLE_DELAY + SAMPLE_HOLD + 8 ticks plus one
	// store cycle. A slow prescaler stretches all ticked phases alike.
	// Switching the clock source mid-run would mix two tick rates
	// inside one phase; the register does not block it, software must.
	wire cnt_done    = (state_reg == CONV_DELAY) ? (cnt_reg == DELAY_LAST) : (cnt_reg == HOLD_LAST);
	wire stored      = (state_reg == CONV_STORE);
	wire [2:0] trial_idx = bit_idx_reg;

	// Trial bit set, previous decision kept or dropped
	always_comb begin
		sar_next = sar_reg;
		if (!comparator_high) begin
			sar_next[trial_idx] = 1'b0;
		end
		if (trial_idx != 3'h0) begin
			sar_next[trial_idx - 3'h1] = 1'b1;
		end
	end

	// Next state of the sequence
	always_comb begin
		state_next = state_reg;
		unique case (state_reg)
			CONV_IDLE:   if (start_take) state_next = CONV_DELAY;
			CONV_DELAY:  if (conv_tick && cnt_done) state_next = CONV_SAMPLE;
			CONV_SAMPLE: if (conv_tick && cnt_done) state_next = CONV_SAR;
			CONV_SAR:    if (conv_tick && trial_idx == 3'h0) state_next = CONV_STORE;
			CONV_STORE:  state_next = CONV_IDLE;
			default:     state_next = CONV_IDLE; // Unused codes recover to idle
		endcase
	end

	// Sequencer state and phase counter
	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_reg <= CONV_IDLE;
			cnt_reg   <= 8'h00;
		end else begin
			state_reg <= state_next;
			if (state_next != state_reg) begin
				cnt_reg <= 8'h00;
			end else if (conv_tick) begin
				cnt_reg <= cnt_reg + 8'h01;
			end
		end
	end

	// Successive approximation, MSB first
	always_ff @(posedge core_clk) begin
		if (rst) begin
			sar_reg     <= 8'h00;
			bit_idx_reg <= 3'h7;
		end else if (state_reg == CONV_SAMPLE && state_next == CONV_SAR) begin
			sar_reg     <= 8'h80;
			bit_idx_reg <= 3'h7;
		end else if (state_reg == CONV_SAR && conv_tick) begin
			sar_reg     <= sar_next;
			bit_idx_reg <= bit_idx_reg - 3'h1;
		end
	end

	// Result has no reset: undefined until the first conversion
	always_ff @(posedge core_clk) begin
		if (state_reg == CONV_SAR && state_next == CONV_STORE) begin
			result_reg <= sar_next;
		end
	end

	// ------------------------------------------------------------
	// Control, pin enable and mask registers
	// ------------------------------------------------------------
	// Select and source bits accept writes even while busy; keeping them stable is software's job
	always_ff @(posedge core_clk) begin
		if (rst) begin
			channel_select_lo_reg     <= CONTROL_INIT[`CHAN_SEL_LO_BIT];
			channel_select_hi_reg     <= CONTROL_INIT[`CHAN_SEL_HI_BIT];
			conv_clock_source_sel_reg <= CONTROL_INIT[`CLK_SRC_BIT];
		end else if (wr_control) begin
			channel_select_lo_reg     <= reg_wdata[`CHAN_SEL_LO_BIT];
			channel_select_hi_reg     <= reg_wdata[`CHAN_SEL_HI_BIT];
			conv_clock_source_sel_reg <= reg_wdata[`CLK_SRC_BIT];
		end
	end

	// Analog pin enables; a change mid-conversion corrupts only that result
	always_ff @(posedge core_clk) begin
		if (rst) begin
			pin_enable_reg <= `PIN_ENABLE_RESET;
		end else if (wr_pins) begin
			pin_enable_reg <= reg_wdata;
		end
	end

	// Completion interrupt mask
	always_ff @(posedge core_clk) begin
		if (rst) begin
			conv_done_irq_enable_reg <= `IRQ_MASK_RESET;
		end else if (wr_mask) begin
			conv_done_irq_enable_reg <= reg_wdata[`IRQ_BIT];
		end
	end

	// Completion flag: a store in the clearing cycle wins
	always_ff @(posedge core_clk) begin
		if (rst) begin
			conv_done_flag_reg <= `IRQ_FLAG_RESET;
		end else if (stored) begin
			conv_done_flag_reg <= 1'b1;
		end else if (flag_clear) begin
			conv_done_flag_reg <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Read data, one cycle after the strobe
	// ------------------------------------------------------------
	wire [3:0] control_view = {1'b0, conv_clock_source_sel_reg, channel_select_hi_reg, channel_select_lo_reg};
	wire [3:0] read_mux =
		hit_control ? control_view :
		hit_pins    ? pin_enable_reg :
		hit_res_lo  ? result_reg[3:0] :
		hit_res_hi  ? result_reg[7:4] :
		hit_mask    ? {3'h0, conv_done_irq_enable_reg} :
		hit_flag    ? {3'h0, conv_done_flag_reg} : 4'h0;

	always_ff @(posedge core_clk) begin
		if (rst) begin
			reg_rdata <= 4'h0;
		end else begin
			reg_rdata <= reg_read ? read_mux : 4'h0;
		end
	end

	// ------------------------------------------------------------
	// Front-end and interrupt outputs, all registered
	// ------------------------------------------------------------
	// Interrupt condition; the CPU's global enable is the last gate
	wire irq_next = conv_done_flag_reg && conv_done_irq_enable_reg && cpu_irq_enable;

	// Output values one cycle ahead of the pins
	wire       busy_next  = (state_next != CONV_IDLE);
	wire       hold_next  = (state_next == CONV_SAMPLE);
	wire       sar_enter  = (state_reg == CONV_SAMPLE) && (state_next == CONV_SAR);
	wire       sar_step   = (state_reg == CONV_SAR) && conv_tick;
	wire [7:0] trial_next = sar_enter ? 8'h80 : (sar_step ? sar_next : sar_reg);
	wire [1:0] chan_next  = {channel_select_hi_reg, channel_select_lo_reg};

	// Channel mux passes a disabled pin anyway; its result is simply not meaningful
	always_ff @(posedge core_clk) begin
		if (rst) begin
			analog_pin_enable <= `PIN_ENABLE_RESET;
		end else begin
			analog_pin_enable <= pin_enable_reg;
		end
	end

	// Channel select follows the register, even mid-conversion
	always_ff @(posedge core_clk) begin
		if (rst) begin
			sample_channel <= 2'h0;
		end else begin
			sample_channel <= chan_next;
		end
	end

	// Sample-and-hold strobe for the sample phase
	always_ff @(posedge core_clk) begin
		if (rst) begin
			sample_hold <= 1'b0;
		end else begin
			sample_hold <= hold_next;
		end
	end

	// Trial code, in step with the approximation register
	always_ff @(posedge core_clk) begin
		if (rst) begin
			sar_trial <= 8'h00;
		end else begin
			sar_trial <= trial_next;
		end
	end

	// Busy, high for the whole sequence including the store cycle
	always_ff @(posedge core_clk) begin
		if (rst) begin
			conv_busy <= 1'b0;
		end else begin
			conv_busy <= busy_next;
		end
	end

	// Level interrupt, registered so the pin never glitches
	always_ff @(posedge core_clk) begin
		if (rst) begin
			adc_irq <= 1'b0;
		end else begin
			adc_irq <= irq_next;
		end
	end

endmodule : adc_control_and_irq

//--- adc_control_and_irq_tb.sv
// Self-checking testbench of the converter control block
module adc_control_and_irq_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import adc_ctrl_pkg::*;
	logic core_clk, rst, reg_write, reg_read, osc_half_tick, prescaler_clock, sample_hold;
	logic comparator_high, conv_busy, cpu_irq_enable, adc_irq;
	addr_t reg_addr;
	nibble_t reg_wdata, reg_rdata, d;
	logic [3:0] analog_pin_enable;
	logic [1:0] sample_channel;
	result_t sar_trial, e;
	logic [31:0] levels;
	int checks, bad_count, cyc, n, n_osc, n_prs;
	addr_t ra[5] = '{16'hFF68, 16'hFF69, 16'hFFE7, 16'hFFF7, 16'hFF6C};
	// Short phases keep conversions brief
	adc_control_and_irq #(.SAMPLE_DELAY(2), .SAMPLE_HOLD(2)) adc_control_and_irq_i (.core_clk, .rst, .reg_addr,
		.reg_wdata, .reg_write, .reg_read, .reg_rdata, .osc_half_tick, .prescaler_clock, .analog_pin_enable,
		.sample_channel, .sample_hold, .sar_trial, .comparator_high, .conv_busy, .cpu_irq_enable, .adc_irq);
	analog_front_model analog_front_model_i (.core_clk, .levels, .analog_pin_enable, .sample_channel,
		.sample_hold, .sar_trial, .comparator_high);
	// Clock and ticks: oscillator/2 every second cycle, prescaler every fifth
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		osc_half_tick <= (cyc % 2 == 0);
		prescaler_clock <= (cyc % 5 == 0);
	end
	// ------
	// Tasks
	// ------
	// An idle cycle follows each strobe so no strobe is assigned twice at one edge
	task automatic wr(input addr_t a, input nibble_t v);
		reg_addr <= a;
		reg_wdata <= v;
		reg_write <= 1'b1;
		@(posedge core_clk);
		reg_write <= 1'b0;
		@(posedge core_clk);
	endtask : wr
	task automatic rd(input addr_t a, output nibble_t v);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge core_clk);
		reg_read <= 1'b0;
		#1 v = reg_rdata;
		@(posedge core_clk);
	endtask : rd
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// Start, optionally start again while busy, count cycles until busy drops
	task automatic conv(input logic [1:0] ch, input logic src, input logic again, output int c);
		c = 0;
		wr(16'hFF68, {1'b1, src, ch});
		if (again) begin
			repeat (10) @(posedge core_clk);
			wr(16'hFF68, {1'b1, src, ch});
		end
		do begin
			@(posedge core_clk);
			#1 c++;
		end while (conv_busy === 1'b1 && c < 500);
		@(posedge core_clk);
	endtask : conv
	// Model code: channel level, or ground when its pin is digital
	function automatic result_t code(input int ch, input logic [3:0] pins);
		return pins[ch] ? levels[ch*8 +: 8] : 8'h00;
	endfunction : code
	task automatic print_verdict;
		$display("checks=%0d bad_count=%0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : print_verdict
	// Hang guard, far beyond the expected four hundred cycles
	initial begin
		repeat (5000) @(posedge core_clk);
		bad_count++;
		print_verdict;
	end
	// ------
	// Tests
	// ------
	initial begin
		{rst, reg_write, reg_read, cpu_irq_enable, osc_half_tick, prescaler_clock} = 6'h20;
		reg_addr = 16'h0000;
		reg_wdata = 4'h0;
		cyc = 0;
		levels = $urandom(94);
		repeat (20) @(posedge core_clk);
		rst <= 1'b0;
		@(posedge core_clk);
		foreach (ra[i]) begin
			rd(ra[i], d);
			chk(d, 8'h00);
		end
		$display("reset values done");
		cpu_irq_enable <= 1'b1;
		wr(16'hFF69, 4'hF);
		for (int ch = 0; ch < 4; ch++) begin
			conv(ch[1:0], ch[0], 1'b0, n);
			if (ch[0])
				n_osc = n;
			else
				n_prs = n;
			e = code(ch, 4'hF);
			rd(16'hFF6A, d);
			chk(d, e[3:0]);
			rd(16'hFF6B, d);
			chk(d, e[7:4]);
			rd(16'hFF68, d);
			chk(d, {1'b0, ch[0], ch[1:0]});
			rd(16'hFFF7, d);
			chk(d, 8'h01);
			chk(adc_irq, 8'h00);
			wr(16'hFFF7, 4'hE);
			rd(16'hFFF7, d);
			chk(d, 8'h01);
			wr(16'hFFF7, 4'h1);
			rd(16'hFFF7, d);
			chk(d, 8'h00);
		end
		chk(n_prs > n_osc + 20, 8'h01);
		wr(16'hFF69, 4'h1);
		conv(2'd2, 1'b1, 1'b0, n);
		e = code(2, 4'h1);
		rd(16'hFF6B, d);
		chk(d, e[7:4]);
		wr(16'hFFF7, 4'h1);
		$display("conversions done");
		wr(16'hFFE7, 4'hF);
		rd(16'hFFE7, d);
		chk(d, 8'h01);
		conv(2'd1, 1'b1, 1'b0, n);
		#1 chk(adc_irq, 8'h01);
		@(posedge core_clk);
		cpu_irq_enable <= 1'b0;
		repeat (2) @(posedge core_clk);
		#1 chk(adc_irq, 8'h00);
		@(posedge core_clk);
		cpu_irq_enable <= 1'b1;
		repeat (2) @(posedge core_clk);
		#1 chk(adc_irq, 8'h01);
		@(posedge core_clk);
		wr(16'hFFE7, 4'h0);
		#1 chk(adc_irq, 8'h00);
		@(posedge core_clk);
		wr(16'hFFE7, 4'h1);
		#1 chk(adc_irq, 8'h01);
		@(posedge core_clk);
		wr(16'hFFF7, 4'h1);
		#1 chk(adc_irq, 8'h00);
		@(posedge core_clk);
		$display("interrupt done");
		wr(16'hFF68, 4'h3);
		#1 chk(conv_busy, 8'h00);
		@(posedge core_clk);
		conv(2'd3, 1'b1, 1'b1, n);
		chk(n + 12 <= n_osc + 2 && n + 14 >= n_osc, 8'h01);
		$display("start handling done");
		print_verdict;
	end
endmodule : adc_control_and_irq_tb

//--- adc_ctrl_consts.svh
// Register offsets, field positions, reset values and timing counts of the converter control
`ifndef ADC_CTRL_CONSTS_SVH
`define ADC_CTRL_CONSTS_SVH

`define ADC_CONTROL_OFS      16'hFF68
`define ADC_PIN_ENABLE_OFS   16'hFF69
`define ADC_RESULT_LOW_OFS   16'hFF6A
`define ADC_RESULT_HIGH_OFS  16'hFF6B
`define ADC_IRQ_MASK_OFS     16'hFFE7
`define ADC_IRQ_FLAG_OFS     16'hFFF7

`define CHAN_SEL_LO_BIT      0
`define CHAN_SEL_HI_BIT      1
`define CLK_SRC_BIT          2
`define START_BIT            3
`define IRQ_BIT              0

`define CONTROL_RESET        4'h0
`define PIN_ENABLE_RESET     4'h0
`define IRQ_MASK_RESET       1'h0
`define IRQ_FLAG_RESET       1'h0

`define SAMPLE_DELAY_CYCLES  4
`define SAMPLE_HOLD_CYCLES   4

`endif

//--- adc_ctrl_monitor.sv
// Concurrent checks on the ports of the converter control block
module adc_ctrl_monitor (
	// Clock and reset
	input wire logic                  core_clk,
	input wire logic                  rst,
	// Register port
	input wire adc_ctrl_pkg::addr_t   reg_addr,
	input wire adc_ctrl_pkg::nibble_t reg_wdata,
	input wire logic                  reg_write,
	input wire logic                  reg_read,
	input wire adc_ctrl_pkg::nibble_t reg_rdata,
	// Pin enables, status and interrupt
	input wire logic [3:0]            analog_pin_enable,
	input wire logic                  conv_busy,
	input wire logic                  cpu_irq_enable,
	input wire logic                  adc_irq
);
	import adc_ctrl_pkg::*;
	// Decoded start writes; one clock domain
	wire start_wr = reg_write && reg_addr == 16'hFF68 && reg_wdata[3];
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);
	chk_start_busy: assert property (start_wr && !conv_busy |=> conv_busy)
		else $error("idle start did not raise busy");
	chk_busy_holds: assert property (start_wr && conv_busy |=> conv_busy)
		else $error("start while busy dropped busy");
	chk_start_reads: assert property (reg_read && reg_addr == 16'hFF68 |=> !reg_rdata[3])
		else $error("start bit read as one");
	chk_upper_zero: assert property (reg_read && (reg_addr == 16'hFFE7 || reg_addr == 16'hFFF7) |=> reg_rdata[3:1] == 3'h0)
		else $error("unused bits read nonzero");
	chk_pin_copy: assert property (reg_write && reg_addr == 16'hFF69 ##1 !reg_write |=> analog_pin_enable == $past(reg_wdata, 2))
		else $error("pin enables differ from write");
	chk_irq_gate: assert property (adc_irq |-> $past(cpu_irq_enable))
		else $error("irq while globally disabled");
	chk_mask_off: assert property (reg_write && reg_addr == 16'hFFE7 && !reg_wdata[0] |=> ##1 !adc_irq)
		else $error("irq despite mask");
	chk_flag_clear: assert property (reg_write && reg_addr == 16'hFFF7 && reg_wdata[0] && !conv_busy |=> ##1 !adc_irq)
		else $error("irq after flag clear");
	chk_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 4'h0)
		else $error("read data outside its cycle");
	// Main scenarios reached
	cover property ($rose(adc_irq));
	cover property (start_wr && conv_busy);
	cover property ($fell(conv_busy));
endmodule : adc_ctrl_monitor
bind adc_control_and_irq adc_ctrl_monitor adc_ctrl_monitor_i (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_write,
	.reg_read, .reg_rdata, .analog_pin_enable, .conv_busy, .cpu_irq_enable, .adc_irq);

//--- adc_ctrl_pkg.sv
// Types shared by the converter control block
package adc_ctrl_pkg;
	typedef logic [3:0]  nibble_t;
	typedef logic [15:0] addr_t;
	typedef logic [1:0]  chan_t;
	typedef logic [7:0]  result_t;
	typedef enum logic [2:0] {
		CONV_IDLE,
		CONV_DELAY,
		CONV_SAMPLE,
		CONV_SAR,
		CONV_STORE
	} conv_state_e;
endpackage : adc_ctrl_pkg

//--- analog_front_model.sv
// Behavioural analog front end: channel levels, sample-and-hold and comparator
module analog_front_model (
	// Clock
	input wire logic                  core_clk,
	// Channel levels, channel 0 in the low byte
	input wire logic [31:0]           levels,
	// Controls from the block
	input wire logic [3:0]            analog_pin_enable,
	input wire logic [1:0]            sample_channel,
	input wire logic                  sample_hold,
	input wire adc_ctrl_pkg::result_t sar_trial,
	// Decision
	output logic                      comparator_high
);
	import adc_ctrl_pkg::*;
	result_t held_reg;
	// Track while sampling; a pin left digital reads as ground, so its code is useless
	always_ff @(posedge core_clk)
		if (sample_hold)
			held_reg <= analog_pin_enable[sample_channel] ? levels[sample_channel*8 +: 8] : 8'h00;
	// Held level compared against the trial code
	assign comparator_high = held_reg >= sar_trial;
endmodule : analog_front_model
